// >>> psfi_defs.svh
`ifndef PSFI_DEFS_SVH
`define PSFI_DEFS_SVH

// ==========================================================
// register offsets
`define PSFI_OFS_GLOBAL 8'h00
`define PSFI_OFS_REGUL 8'h01
`define PSFI_OFS_GMASK 8'h02
`define PSFI_OFS_VMASK 8'h03

// ==========================================================
// reset values
`define PSFI_GFLAG_RST 5'h00
`define PSFI_VFLAG_RST 6'h00
`define PSFI_GMASK_RST 8'h01
`define PSFI_VMASK_RST 6'h00

// ==========================================================
// global flag bit positions
`define PSFI_G_FUSE_LOAD 0
`define PSFI_G_FUSE_CRC 1
`define PSFI_G_BUS_FAULT 2
`define PSFI_G_OVER_TEMP 3
`define PSFI_G_REG_SUM 4

// ==========================================================
// regulation flag layout: regained in [2:0], lost in [5:3]
`define PSFI_V_REGAIN_LSB 0
`define PSFI_V_LOST_LSB 3
`define PSFI_N_OUTPUTS 3

`endif

// >>> psfi_pkg.sv
`default_nettype none

package psfi_pkg;
  typedef logic [7:0] psfi_byte_t;
  typedef logic [4:0] psfi_gflags_t;
  typedef logic [5:0] psfi_vflags_t;
  typedef enum logic [2:0] {
    PSFI_SEL_GLOBAL,
    PSFI_SEL_REGUL,
    PSFI_SEL_GMASK,
    PSFI_SEL_VMASK,
    PSFI_SEL_NONE
  } psfi_sel_e;
endpackage

`default_nettype wire

// >>> psfi_flag_bank.sv
`default_nettype none

module psfi_flag_bank #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events and clears
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic [WIDTH-1:0] clr_pulse,
  // flags
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_reg;

  // ==========================================================
  // sticky flags, one per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flags_reg[i] <= RESET_VAL[i];
        end else if (set_pulse[i]) begin
          // set wins over a clear in the same cycle so no event is lost
          flags_reg[i] <= 1'b1;
        end else if (clr_pulse[i]) begin
          flags_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags = flags_reg;

endmodule // psfi_flag_bank

`default_nettype wire

// >>> psfi_trans_det.sv
`default_nettype none

module psfi_trans_det #(
  parameter int N = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // live in-regulation levels
  input wire logic [N-1:0] in_reg,
  // transition pulses
  output logic [N-1:0] lost,
  output logic [N-1:0] regained
);

  logic [N-1:0] prev_reg;
  logic primed_reg;

  // ==========================================================
  // history; the first sample after reset only primes it, so the
  // start-up level of an output is not reported as a transition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= in_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primed_reg <= 1'b0;
    end else begin
      primed_reg <= 1'b1;
    end
  end

  assign lost = {N{primed_reg}} & prev_reg & ~in_reg;
  assign regained = {N{primed_reg}} & ~prev_reg & in_reg;

endmodule // psfi_trans_det

`default_nettype wire

// >>> psfi_top.sv
`include "psfi_defs.svh"
`default_nettype none

// What this block does
// RULE_01 - over-temperature sample above limit sets flag
// RULE_02 - temperature evaluated only with nonzero sample period
// RULE_03 - temperature, bus, checksum flags masked after reset
// RULE_04 - serial-bus fault sets sticky bus flag
// RULE_05 - fuse checksum fault sets sticky checksum flag
// RULE_06 - every reset release loads fuses, sets bit 0
// RULE_07 - fuse-load flag unmasked after reset, raises interrupt
// RULE_08 - host clears fuse-load flag after power-up
// RULE_09 - host keeps fuse-load flag unmasked permanently
// RULE_10 - writing one clears flag, zero keeps it
// RULE_11 - host writes zeros to reserved bits 7:6
// RULE_12 - third output losing regulation sets bit 5
// RULE_13 - second output losing regulation sets bit 4
// RULE_14 - first output losing regulation sets bit 3
// RULE_15 - third output regaining regulation sets bit 2
// RULE_16 - second output regaining regulation sets bit 1
// RULE_17 - host uses live state for regulation status
// RULE_18 - any unmasked regulation flag sets summary flag
// RULE_19 - regulation mask bit one passes flag on
// RULE_20 - interrupt asserted while any unmasked global flag
// RULE_21 - all flags zero after reset except fuse-load
module psfi_top #(
  parameter int TEMP_W = 8,
  parameter int PERIOD_W = 3
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // register port from the serial interface
  input wire psfi_pkg::psfi_byte_t REG_ADDR,
  input wire logic REG_WR,
  input wire psfi_pkg::psfi_byte_t REG_WDATA,
  input wire logic REG_RD,
  output psfi_pkg::psfi_byte_t REG_RDATA,
  // converter
  input wire logic ADC_TEMP_VALID,
  input wire logic [TEMP_W-1:0] ADC_TEMP_CODE,
  input wire logic [TEMP_W-1:0] TEMP_LIMIT_FIELD,
  input wire logic [PERIOD_W-1:0] CONVERSION_PERIOD_FIELD,
  // fault and load events
  input wire logic BUS_FAULT,
  input wire logic FUSE_CRC_FAULT,
  input wire logic FUSE_LOAD_DONE,
  // live regulation state of the three outputs
  input wire logic [2:0] OUT_IN_REG,
  // outputs
  output logic FUSE_LOAD_START,
  output logic IRQ_N
);
  import psfi_pkg::*;

  psfi_sel_e sel;
  logic wr_global;
  logic wr_regul;
  logic boot_reg;
  logic over_temp;
  logic irq_reg;
  psfi_byte_t rdata_reg;
  psfi_byte_t gmask_reg;
  psfi_vflags_t vmask_reg;
  psfi_gflags_t gflags;
  psfi_gflags_t gset;
  psfi_gflags_t gclr;
  psfi_vflags_t vflags;
  psfi_vflags_t vset;
  psfi_vflags_t vclr;
  logic [2:0] out_lost;
  logic [2:0] out_regained;

  // ==========================================================
  // address decode
  always_comb begin
    case (REG_ADDR)
      `PSFI_OFS_GLOBAL: sel = PSFI_SEL_GLOBAL;
      `PSFI_OFS_REGUL: sel = PSFI_SEL_REGUL;
      `PSFI_OFS_GMASK: sel = PSFI_SEL_GMASK;
      `PSFI_OFS_VMASK: sel = PSFI_SEL_VMASK;
      default: sel = PSFI_SEL_NONE;
    endcase
  end

  assign wr_global = REG_WR && (sel == PSFI_SEL_GLOBAL);
  assign wr_regul = REG_WR && (sel == PSFI_SEL_REGUL);

  // ==========================================================
  // fuse load after reset release
  // high through reset, dropped on the first edge after release; the reset itself is the load request
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  assign FUSE_LOAD_START = boot_reg; // RULE_06

  // ==========================================================
  // global events
  // the comparison is skipped when no periodic sampling is programmed
  assign over_temp = ADC_TEMP_VALID && (CONVERSION_PERIOD_FIELD != '0) // RULE_02
                     && (ADC_TEMP_CODE > TEMP_LIMIT_FIELD); // RULE_01

  always_comb begin
    gset = '0;
    gset[`PSFI_G_FUSE_LOAD] = boot_reg || FUSE_LOAD_DONE; // RULE_06
    gset[`PSFI_G_FUSE_CRC] = FUSE_CRC_FAULT; // RULE_05
    gset[`PSFI_G_BUS_FAULT] = BUS_FAULT; // RULE_04
    gset[`PSFI_G_OVER_TEMP] = over_temp; // RULE_01
    // summary is set as a level by the masked regulation flags, then held until the host clears it
    gset[`PSFI_G_REG_SUM] = |(vflags & vmask_reg); // RULE_18 RULE_19
  end

  assign gclr = wr_global ? REG_WDATA[4:0] : '0; // RULE_10

  psfi_flag_bank #(
    .WIDTH(5),
    .RESET_VAL(`PSFI_GFLAG_RST) // RULE_21
  ) u_global_flags (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .set_pulse(gset),
    .clr_pulse(gclr),
    .flags(gflags)
  );

  // ==========================================================
  // regulation events
  psfi_trans_det #(
    .N(`PSFI_N_OUTPUTS)
  ) u_trans (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .in_reg(OUT_IN_REG),
    .lost(out_lost),
    .regained(out_regained)
  );

  assign vset = {out_lost, out_regained}; // RULE_12 RULE_13 RULE_14 RULE_15 RULE_16
  // reserved bits 7:6 are dropped from the clear
  assign vclr = wr_regul ? REG_WDATA[5:0] : '0; // RULE_10 RULE_11

  psfi_flag_bank #(
    .WIDTH(6),
    .RESET_VAL(`PSFI_VFLAG_RST) // RULE_21
  ) u_regul_flags (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .set_pulse(vset),
    .clr_pulse(vclr),
    .flags(vflags)
  );

  // ==========================================================
  // mask registers
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      gmask_reg <= `PSFI_GMASK_RST; // RULE_03 RULE_07
    end else if (REG_WR && (sel == PSFI_SEL_GMASK)) begin
      gmask_reg <= REG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      vmask_reg <= `PSFI_VMASK_RST;
    end else if (REG_WR && (sel == PSFI_SEL_VMASK)) begin
      vmask_reg <= REG_WDATA[5:0]; // RULE_19
    end
  end

  // ==========================================================
  // interrupt pin, active low, registered to avoid glitches on the pad
  // a flag raised in one cycle reaches the pin one cycle later
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(gflags & gmask_reg[4:0]); // RULE_20
    end
  end

  assign IRQ_N = ~irq_reg;

  // ==========================================================
  // read data; global bits 7:5 and regulation bits 7:6 read zero
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= 8'h00;
    end else if (REG_RD) begin
      case (sel)
        PSFI_SEL_GLOBAL: rdata_reg <= {3'h0, gflags};
        PSFI_SEL_REGUL: rdata_reg <= {2'h0, vflags};
        PSFI_SEL_GMASK: rdata_reg <= gmask_reg;
        PSFI_SEL_VMASK: rdata_reg <= {2'h0, vmask_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign REG_RDATA = rdata_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  sequence temp_hot_s;
    ADC_TEMP_VALID && (CONVERSION_PERIOD_FIELD != '0) && (ADC_TEMP_CODE > TEMP_LIMIT_FIELD);
  endsequence

  sequence fuse_flag_up_s;
    gflags[`PSFI_G_FUSE_LOAD] && gmask_reg[`PSFI_G_FUSE_LOAD];
  endsequence

  // fuse load request in the boot cycle, before the flag is seen
  sequence boot_s;
    boot_reg && FUSE_LOAD_START;
  endsequence

  sequence irq_cause_s;
    |(gflags & gmask_reg[4:0]);
  endsequence

  over_temp_set_a: assert property (temp_hot_s |=> gflags[`PSFI_G_OVER_TEMP]) // RULE_01
    else $error("over-temperature flag not set after hot sample");

  temp_needs_period_a: assert property ( // RULE_02
    $rose(gflags[`PSFI_G_OVER_TEMP]) |-> $past(CONVERSION_PERIOD_FIELD) != '0)
    else $error("over-temperature flag set with zero sample period");

  masks_after_reset_a: assert property ( // RULE_03
    boot_reg |-> (gmask_reg == `PSFI_GMASK_RST) && (vmask_reg == `PSFI_VMASK_RST))
    else $error("mask registers not at reset value after release");

  bus_fault_set_a: assert property ( // RULE_04
    BUS_FAULT |=> gflags[`PSFI_G_BUS_FAULT] ##1
      (gflags[`PSFI_G_BUS_FAULT] || $past(gclr[`PSFI_G_BUS_FAULT])))
    else $error("bus fault flag not held");

  crc_fault_set_a: assert property (FUSE_CRC_FAULT |=> gflags[`PSFI_G_FUSE_CRC]) // RULE_05
    else $error("checksum fault flag not set");

  boot_load_a: assert property ( // RULE_06
    boot_s |=> (!FUSE_LOAD_START && gflags[`PSFI_G_FUSE_LOAD]))
    else $error("reset release did not load fuses and set flag");

  boot_irq_a: assert property (boot_reg |-> ##2 !IRQ_N) // RULE_07
    else $error("interrupt pin not asserted after reset release");

  flag_clear_a: assert property ( // RULE_10
    wr_regul && !(|vset) |=> ((vflags & $past(vclr)) == 6'h00))
    else $error("write of one did not clear regulation flag");

  flag_keep_a: assert property ( // RULE_10
    wr_global |=> ((($past(gflags) & ~$past(gclr)) & ~gflags) == 5'h00))
    else $error("write of zero changed a global flag");

  out_lost_a: assert property ( // RULE_12 RULE_13 RULE_14
    |out_lost |=> ((vflags[5:3] & $past(out_lost)) == $past(out_lost)))
    else $error("lost-regulation flag not set");

  out_regain_a: assert property ( // RULE_15 RULE_16
    |out_regained |=> ((vflags[2:0] & $past(out_regained)) == $past(out_regained)))
    else $error("regained-regulation flag not set");

  summary_set_a: assert property (|(vflags & vmask_reg) |=> gflags[`PSFI_G_REG_SUM]) // RULE_18
    else $error("summary flag not set by unmasked regulation flag");

  irq_follow_a: assert property ( // RULE_20
    !(|(gflags & gmask_reg[4:0])) |=> IRQ_N)
    else $error("interrupt asserted with no unmasked flag");

  flags_clean_a: assert property ( // RULE_21
    boot_reg |-> (vflags == 6'h00) && (gflags == 5'h00))
    else $error("flags not clear after reset");

  fuse_irq_a: assert property (fuse_flag_up_s |=> !IRQ_N) // RULE_07
    else $error("unmasked fuse-load flag did not assert interrupt");

  irq_raise_a: assert property (irq_cause_s |=> !IRQ_N) // RULE_20
    else $error("unmasked flag did not assert interrupt");

  summary_masked_a: assert property ( // RULE_19
    !(|(vflags & vmask_reg)) && !gflags[`PSFI_G_REG_SUM] |=> !gflags[`PSFI_G_REG_SUM])
    else $error("summary flag set with every regulation flag masked");

  // with no valid sample or no sampling period the flag must stay down
  temp_idle_a: assert property ( // RULE_02
    (!ADC_TEMP_VALID || (CONVERSION_PERIOD_FIELD == '0)) && !gflags[`PSFI_G_OVER_TEMP]
    |=> !gflags[`PSFI_G_OVER_TEMP])
    else $error("over-temperature flag set without a valid periodic sample");

  fuse_done_set_a: assert property (FUSE_LOAD_DONE |=> gflags[`PSFI_G_FUSE_LOAD]) // RULE_06
    else $error("fuse-load flag not set by completed load");

  vflag_keep_a: assert property ( // RULE_10
    wr_regul |=> ((($past(vflags) & ~$past(vclr)) & ~vflags) == 6'h00))
    else $error("write of zero changed a regulation flag");

endmodule // psfi_top

`default_nettype wire

// >>> psfi_host_model.sv
`include "psfi_defs.svh"
`default_nettype none

// ==========================================================
// host controller on the far side of the register port
module psfi_host_model (
  // clock
  input wire logic clk,
  // register port
  output psfi_pkg::psfi_byte_t addr,
  output logic wr,
  output psfi_pkg::psfi_byte_t wdata,
  output logic rd,
  input wire psfi_pkg::psfi_byte_t rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import psfi_pkg::*;

  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // released lines show the inverse, so a stale value cannot pass
  task automatic put(input psfi_byte_t a, input psfi_byte_t d);
    psfi_byte_t v;
    v = d;
    if (a == `PSFI_OFS_REGUL) begin
      v = d & 8'h3F;
    end
    if (a == `PSFI_OFS_GMASK) begin
      v = d | 8'h01;
    end
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~v;
  endtask

  task automatic get(input psfi_byte_t a, output psfi_byte_t d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    addr = ~a;
  endtask
endmodule // psfi_host_model

`default_nettype wire

// >>> tb.sv
`include "psfi_defs.svh"
`default_nettype none

// ==========================================================
// self-checking bench for the status flag block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psfi_pkg::*;

  logic sys_clk, rstn, rd, wr, fuse_start, irq_n;
  psfi_byte_t addr, wdata, rdata;
  // event strobes: 0 bus fault, 1 checksum, 2 load done, 3 temp valid
  logic [3:0] evt;
  logic [7:0] temp_code, temp_lim;
  logic [2:0] period, out_reg;
  int fails = 0;
  int n_compared = 0;

  psfi_top u_dut (
    .SYS_CLK(sys_clk), .RSTN(rstn),
    .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
    .ADC_TEMP_VALID(evt[3]), .ADC_TEMP_CODE(temp_code), .TEMP_LIMIT_FIELD(temp_lim),
    .CONVERSION_PERIOD_FIELD(period),
    .BUS_FAULT(evt[0]), .FUSE_CRC_FAULT(evt[1]), .FUSE_LOAD_DONE(evt[2]),
    .OUT_IN_REG(out_reg), .FUSE_LOAD_START(fuse_start), .IRQ_N(irq_n)
  );

  psfi_host_model u_host (
    .clk(sys_clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic irqc(input logic v);
    chk({7'h00, irq_n}, {7'h00, v});
  endtask

  task automatic rd_chk(input psfi_byte_t a, input psfi_byte_t exp);
    psfi_byte_t d;
    u_host.get(a, d);
    chk(d, exp);
  endtask

  task automatic ev(input int i);
    @(negedge sys_clk);
    evt[i] = 1'b1;
    @(negedge sys_clk);
    evt[i] = 1'b0;
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // also used again after the other tests, where every flag and mask must fall back
  task automatic t_reset();
    rstn = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({7'h00, fuse_start}, 8'h01);
    irqc(1'b1);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, fuse_start}, 8'h00);
    irqc(1'b0);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h01);
    rd_chk(`PSFI_OFS_REGUL, 8'h00);
    rd_chk(`PSFI_OFS_GMASK, 8'h01);
    rd_chk(`PSFI_OFS_VMASK, 8'h00);
    u_host.put(`PSFI_OFS_GLOBAL, 8'h01);
    @(negedge sys_clk);
    irqc(1'b1);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_global();
    temp_code = 8'h40;
    ev(3);
    period = 3'h0;
    temp_code = 8'h41;
    ev(3);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h00);
    period = 3'h1;
    ev(3);
    ev(0);
    ev(1);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h0E);
    irqc(1'b1);
    u_host.put(`PSFI_OFS_GLOBAL, 8'h00);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h0E);
    u_host.put(`PSFI_OFS_GMASK, 8'h04);
    @(negedge sys_clk);
    irqc(1'b0);
    rd_chk(`PSFI_OFS_GMASK, 8'h05);
    u_host.put(`PSFI_OFS_GLOBAL, 8'h04);
    @(negedge sys_clk);
    irqc(1'b1);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h0A);
    u_host.put(`PSFI_OFS_GLOBAL, 8'h0A);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h00);
    $display("test global flags done");
  endtask

  task automatic t_regul();
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk);
      out_reg[i] = 1'b0;
    end
    rd_chk(`PSFI_OFS_REGUL, 8'h38);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h00);
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk);
      out_reg[i] = 1'b1;
    end
    rd_chk(`PSFI_OFS_REGUL, 8'h3F);
    u_host.put(`PSFI_OFS_VMASK, 8'h20);
    @(negedge sys_clk);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h10);
    u_host.put(`PSFI_OFS_GLOBAL, 8'h10);
    @(negedge sys_clk);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h10);
    u_host.put(`PSFI_OFS_REGUL, 8'hE0);
    rd_chk(`PSFI_OFS_REGUL, 8'h1F);
    u_host.put(`PSFI_OFS_GLOBAL, 8'h10);
    @(negedge sys_clk);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h00);
    u_host.put(`PSFI_OFS_REGUL, 8'h1F);
    rd_chk(`PSFI_OFS_REGUL, 8'h00);
    $display("test regulation flags done");
  endtask

  task automatic t_fuse();
    ev(2);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h01);
    irqc(1'b0);
    u_host.put(`PSFI_OFS_GLOBAL, 8'h01);
    rd_chk(`PSFI_OFS_GLOBAL, 8'h00);
    $display("test fuse load done");
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    results();
  end

  initial begin
    rstn = 1'b0;
    evt = 4'h0;
    temp_code = 8'h00;
    temp_lim = 8'h40;
    period = 3'h1;
    out_reg = 3'h7;
    t_reset();
    t_global();
    t_regul();
    t_fuse();
    t_reset();
    results();
  end
endmodule // tb

`default_nettype wire
